/* File: rtl/pae_phy_tx_entry.v */
// phy management addressing, register set and transmit encoders for two ports
// Functional notes
// (RULE1) each port phy has its own mii
// (RULE2) virtual phy shows port 0 as one phy
// (RULE3) full/half duplex at 100 or 10 mbps
// (RULE4) standard management registers, indirect or direct
// (RULE5) strap picks default management addresses
// (RULE6) software overrides port 1 and 2 addresses
// (RULE7) software keeps addresses unique, no check
// (RULE8) strap latched at reset release only
// (RULE9) mac drives nibbles, enable and error
// (RULE10) each nibble becomes one code group
// (RULE11) nibbles 0 to 2 code groups
// (RULE12) nibbles 3 to 5 code groups
// (RULE13) only sixteen patterns carry data
// (RULE14) idle and error symbols differ from data
// (RULE15) idle while transmit enable low
// (RULE16) start pair on enable rise
// (RULE17) end pair on enable fall
// (RULE18) transmit error sends error symbol
// (RULE19) one code group per nibble clock
// (RULE20) nibbles 6 to f standard table
`timescale 1ns/10ps
`include "pae_defs.vh"

module pae_phy_tx_entry (
    // clock and reset
    input wire CLK,
    input wire RESET,
    // configuration strap
    input wire ADDR_SEL_STRAP,
    // management access
    input wire MGMT_REQ,
    input wire MGMT_WRITE,
    input wire MGMT_DIRECT_VPHY,
    input wire [4:0] MGMT_PHY_ADDR,
    input wire [4:0] MGMT_REG_ADDR,
    input wire [15:0] MGMT_WDATA,
    output reg [15:0] MGMT_RDATA,
    output reg MGMT_RVALID,
    output reg [2:0] MGMT_HIT,
    // current management addresses
    output wire [4:0] VPHY_ADDR,
    output wire [4:0] P1_ADDR,
    output wire [4:0] P2_ADDR,
    // operating modes
    output wire VPHY_SPEED_100,
    output wire VPHY_FULL_DUPLEX,
    output wire P1_SPEED_100,
    output wire P1_FULL_DUPLEX,
    output wire P2_SPEED_100,
    output wire P2_FULL_DUPLEX,
    // line status
    input wire P1_LINK_UP,
    input wire P2_LINK_UP,
    // port 1 mii transmit
    input wire [3:0] P1_TXD,
    input wire P1_TX_EN,
    input wire P1_TX_ER,
    output wire [4:0] P1_CODE_GROUP,
    output wire P1_IN_FRAME,
    // port 2 mii transmit
    input wire [3:0] P2_TXD,
    input wire P2_TX_EN,
    input wire P2_TX_ER,
    output wire [4:0] P2_CODE_GROUP,
    output wire P2_IN_FRAME,
    // port 1 receive nibbles from line side
    input wire [3:0] P1_LINE_RXD,
    input wire P1_LINE_RX_DV,
    input wire P1_LINE_RX_ER,
    output reg [3:0] P1_RXD,
    output reg P1_RX_DV,
    output reg P1_RX_ER,
    // port 2 receive nibbles from line side
    input wire [3:0] P2_LINE_RXD,
    input wire P2_LINE_RX_DV,
    input wire P2_LINE_RX_ER,
    output reg [3:0] P2_RXD,
    output reg P2_RX_DV,
    output reg P2_RX_ER
);

    localparam integer NUM_PHY = 3;

    wire [4:0] vphy_addr;
    wire [4:0] p1_addr;
    wire [4:0] p2_addr;
    wire [14:0] addr_flat;
    wire [47:0] rd_flat;
    wire [2:0] link_vec;
    wire [2:0] hit;
    wire [2:0] wr_ctrl;
    wire ovr1_wr;
    wire ovr2_wr;
    wire mgmt_wr;
    wire [2:0] speed_vec;
    wire [2:0] duplex_vec;
    reg [15:0] next_rdata;

    function reg_is;
        input [4:0] reg_addr;
        input [4:0] idx;
        begin
            reg_is = (reg_addr == idx);
        end
    endfunction

    function [15:0] reg_value;
        input [4:0] reg_addr;
        input [15:0] ctrl;
        input link;
        input [4:0] addr;
        begin
            if (reg_is(reg_addr, `PAE_REG_CTRL)) begin
                reg_value = ctrl;
            end else if (reg_is(reg_addr, `PAE_REG_STAT)) begin
                reg_value = `PAE_STAT_ABILITY | ({15'h0000, link} << `PAE_STAT_LINK_BIT);
            end else if (reg_is(reg_addr, `PAE_REG_SMODE)) begin
                reg_value = {11'h000, addr};
            end else begin
                reg_value = 16'h0000;
            end
        end
    endfunction

    // overrides persist until reset, which restores strap defaults
    // (RULE5) strap defaults and overrides
    pae_addr_map u_addr (
        .clk(CLK),
        .reset(RESET),
        .addr_sel_strap(ADDR_SEL_STRAP),
        .ovr1_wr(ovr1_wr),
        .ovr2_wr(ovr2_wr),
        .ovr_data(MGMT_WDATA[`PAE_SMODE_ADDR_MSB:`PAE_SMODE_ADDR_LSB]),
        .vphy_addr(vphy_addr),
        .p1_addr(p1_addr),
        .p2_addr(p2_addr)
    );

    assign VPHY_ADDR = vphy_addr;
    assign P1_ADDR = p1_addr;
    assign P2_ADDR = p2_addr;
    assign addr_flat = {p2_addr, p1_addr, vphy_addr};

    // (RULE2) virtual phy link always up toward host mac
    assign link_vec = {P2_LINK_UP, P1_LINK_UP, 1'b1};

    // (RULE4) direct access reaches virtual phy only, else address match
    // duplicated addresses let several phys match at once
    assign hit[0] = MGMT_DIRECT_VPHY | (MGMT_PHY_ADDR == vphy_addr);
    assign hit[1] = ~MGMT_DIRECT_VPHY & (MGMT_PHY_ADDR == p1_addr);
    assign hit[2] = ~MGMT_DIRECT_VPHY & (MGMT_PHY_ADDR == p2_addr);

    // (RULE7) duplicate addresses all take the write
    assign mgmt_wr = MGMT_REQ & MGMT_WRITE;

    // (RULE6) special-modes writes move port addresses
    assign ovr1_wr = mgmt_wr & hit[1] & reg_is(MGMT_REG_ADDR, `PAE_REG_SMODE);
    assign ovr2_wr = mgmt_wr & hit[2] & reg_is(MGMT_REG_ADDR, `PAE_REG_SMODE);

    genvar i;
    generate
        for (i = 0; i < NUM_PHY; i = i + 1) begin : g_phy
            reg [15:0] ctrl;
            reg [15:0] next_ctrl;
            wire [15:0] rd_val;

            assign wr_ctrl[i] = mgmt_wr & hit[i] & reg_is(MGMT_REG_ADDR, `PAE_REG_CTRL);

            // (RULE3) speed and duplex from control register
            assign speed_vec[i] = ctrl[`PAE_CTRL_SPEED_BIT];
            assign duplex_vec[i] = ctrl[`PAE_CTRL_DUPLEX_BIT];

            // soft reset restores defaults and self clears
            always @* begin
                next_ctrl = ctrl;
                if (wr_ctrl[i]) begin
                    next_ctrl = MGMT_WDATA & ~(16'h0001 << `PAE_CTRL_RESET_BIT);
                end
                if (wr_ctrl[i] & MGMT_WDATA[`PAE_CTRL_RESET_BIT]) begin
                    next_ctrl = `PAE_CTRL_DEFAULT;
                end
            end

            always @(posedge CLK) begin
                if (RESET) begin
                    ctrl <= `PAE_CTRL_DEFAULT;
                end else begin
                    ctrl <= next_ctrl;
                end
            end

            // (RULE4) register view of this phy
            assign rd_val = reg_value(MGMT_REG_ADDR, ctrl, link_vec[i], addr_flat[5*i+4:5*i]);
            assign rd_flat[16*i+15:16*i] = rd_val;
        end
    endgenerate

    assign VPHY_SPEED_100 = speed_vec[0];
    assign VPHY_FULL_DUPLEX = duplex_vec[0];
    assign P1_SPEED_100 = speed_vec[1];
    assign P1_FULL_DUPLEX = duplex_vec[1];
    assign P2_SPEED_100 = speed_vec[2];
    assign P2_FULL_DUPLEX = duplex_vec[2];

    // (RULE4) read answers lowest-numbered matching phy
    // later tests win, so the lowest bit has priority
    always @* begin
        next_rdata = 16'h0000;
        if (hit[2]) begin
            next_rdata = rd_flat[47:32];
        end
        if (hit[1]) begin
            next_rdata = rd_flat[31:16];
        end
        if (hit[0]) begin
            next_rdata = rd_flat[15:0];
        end
    end

    // (RULE4) read pulse one cycle after request
    always @(posedge CLK) begin
        if (RESET) begin
            MGMT_RVALID <= 1'b0;
        end else begin
            MGMT_RVALID <= MGMT_REQ & ~MGMT_WRITE;
        end
    end

    // every matching phy reported, writes included
    always @(posedge CLK) begin
        if (RESET) begin
            MGMT_HIT <= 3'h0;
        end else if (MGMT_REQ) begin
            MGMT_HIT <= hit;
        end else begin
            MGMT_HIT <= 3'h0;
        end
    end

    // read data holds until the next read
    always @(posedge CLK) begin
        if (RESET) begin
            MGMT_RDATA <= 16'h0000;
        end else if (MGMT_REQ & ~MGMT_WRITE) begin
            MGMT_RDATA <= next_rdata;
        end
    end

    // encoders run in either speed mode; speed is only reported
    // (RULE9) mac-driven nibbles into each encoder
    // (RULE1) port 1 transmit path
    pae_enc_4b5b u_enc_p1 (
        .clk(CLK),
        .reset(RESET),
        .txd(P1_TXD),
        .tx_en(P1_TX_EN),
        .tx_er(P1_TX_ER),
        .code_group(P1_CODE_GROUP),
        .in_frame(P1_IN_FRAME)
    );

    // (RULE1) port 2 transmit path
    pae_enc_4b5b u_enc_p2 (
        .clk(CLK),
        .reset(RESET),
        .txd(P2_TXD),
        .tx_en(P2_TX_EN),
        .tx_er(P2_TX_ER),
        .code_group(P2_CODE_GROUP),
        .in_frame(P2_IN_FRAME)
    );

    // (RULE1) receive nibbles back to port 1 mac
    always @(posedge CLK) begin
        if (RESET) begin
            P1_RXD <= 4'h0;
            P1_RX_DV <= 1'b0;
            P1_RX_ER <= 1'b0;
        end else begin
            P1_RXD <= P1_LINE_RXD;
            P1_RX_DV <= P1_LINE_RX_DV;
            P1_RX_ER <= P1_LINE_RX_ER;
        end
    end

    // (RULE1) receive nibbles back to port 2 mac
    always @(posedge CLK) begin
        if (RESET) begin
            P2_RXD <= 4'h0;
            P2_RX_DV <= 1'b0;
            P2_RX_ER <= 1'b0;
        end else begin
            P2_RXD <= P2_LINE_RXD;
            P2_RX_DV <= P2_LINE_RX_DV;
            P2_RX_ER <= P2_LINE_RX_ER;
        end
    end

endmodule

/* File: rtl/pae_defs.vh */
// constants for the phy addressing and 4b/5b transmit entry
`ifndef PAE_DEFS_VH
`define PAE_DEFS_VH

// 4b/5b data code groups, nibble 0 to f
`define PAE_CG_D0 5'h1e
`define PAE_CG_D1 5'h09
`define PAE_CG_D2 5'h14
`define PAE_CG_D3 5'h15
`define PAE_CG_D4 5'h0a
`define PAE_CG_D5 5'h0b
`define PAE_CG_D6 5'h0e
`define PAE_CG_D7 5'h0f
`define PAE_CG_D8 5'h12
`define PAE_CG_D9 5'h13
`define PAE_CG_DA 5'h16
`define PAE_CG_DB 5'h17
`define PAE_CG_DC 5'h1a
`define PAE_CG_DD 5'h1b
`define PAE_CG_DE 5'h1c
`define PAE_CG_DF 5'h1d

// control code groups
// (RULE14) control groups outside data set
`define PAE_CG_IDLE 5'h1f
`define PAE_CG_START_J 5'h18
`define PAE_CG_START_K 5'h11
`define PAE_CG_END_T 5'h0d
`define PAE_CG_END_R 5'h07
`define PAE_CG_TXERR 5'h04

// default management addresses, strap low and strap high
`define PAE_ADDR_VPHY_S0 5'h00
`define PAE_ADDR_P1_S0 5'h01
`define PAE_ADDR_P2_S0 5'h02
`define PAE_ADDR_VPHY_S1 5'h01
`define PAE_ADDR_P1_S1 5'h02
`define PAE_ADDR_P2_S1 5'h03

// management register indices
`define PAE_REG_CTRL 5'h00
`define PAE_REG_STAT 5'h01
`define PAE_REG_SMODE 5'h12

// control register fields and reset value
`define PAE_CTRL_RESET_BIT 15
`define PAE_CTRL_SPEED_BIT 13
`define PAE_CTRL_DUPLEX_BIT 8
`define PAE_CTRL_DEFAULT 16'h3100

// status register: abilities and link bit
`define PAE_STAT_ABILITY 16'h7800
`define PAE_STAT_LINK_BIT 2

// special modes register address field
`define PAE_SMODE_ADDR_MSB 4
`define PAE_SMODE_ADDR_LSB 0

`endif

/* File: rtl/pae_addr_map.v */
// strap-latched default management addresses with per-port overrides
`timescale 1ns/10ps
`include "pae_defs.vh"

module pae_addr_map (
    // clock and reset
    input wire clk,
    input wire reset,
    // strap
    input wire addr_sel_strap,
    // overrides from special-modes writes
    input wire ovr1_wr,
    input wire ovr2_wr,
    input wire [4:0] ovr_data,
    // resulting addresses
    output wire [4:0] vphy_addr,
    output wire [4:0] p1_addr,
    output wire [4:0] p2_addr
);

    reg armed;
    reg strap_q;
    reg ovr1_set;
    reg ovr2_set;
    reg [4:0] ovr1_addr;
    reg [4:0] ovr2_addr;

    // (RULE8) strap caught once at release
    always @(posedge clk) begin
        if (reset) begin
            armed <= 1'b1;
            strap_q <= 1'b0;
        end else if (armed) begin
            armed <= 1'b0;
            strap_q <= addr_sel_strap;
        end
    end

    // (RULE6) software address override
    always @(posedge clk) begin
        if (reset) begin
            ovr1_set <= 1'b0;
            ovr2_set <= 1'b0;
            ovr1_addr <= `PAE_ADDR_P1_S0;
            ovr2_addr <= `PAE_ADDR_P2_S0;
        end else begin
            if (ovr1_wr) begin
                ovr1_set <= 1'b1;
                ovr1_addr <= ovr_data;
            end
            if (ovr2_wr) begin
                ovr2_set <= 1'b1;
                ovr2_addr <= ovr_data;
            end
        end
    end

    // (RULE5) strap selects default table
    assign vphy_addr = strap_q ? `PAE_ADDR_VPHY_S1 : `PAE_ADDR_VPHY_S0;
    assign p1_addr = ovr1_set ? ovr1_addr : (strap_q ? `PAE_ADDR_P1_S1 : `PAE_ADDR_P1_S0);
    assign p2_addr = ovr2_set ? ovr2_addr : (strap_q ? `PAE_ADDR_P2_S1 : `PAE_ADDR_P2_S0);

endmodule

/* File: rtl/pae_enc_4b5b.v */
// 4b/5b transmit encoder with stream delimiters and error symbol
`timescale 1ns/10ps
`include "pae_defs.vh"

module pae_enc_4b5b (
    // clock and reset
    input wire clk,
    input wire reset,
    // mii transmit side
    input wire [3:0] txd,
    input wire tx_en,
    input wire tx_er,
    // code group stream
    output reg [4:0] code_group,
    output wire in_frame
);

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_START_K = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_END_R = 4'h8;

    reg [3:0] state;

    // (RULE13) sixteen data code groups
    // (RULE20) full data table
    function [4:0] data_code;
        input [3:0] nib;
        begin
            case (nib)
                // (RULE11) nibbles 0 to 2
                4'h0: data_code = `PAE_CG_D0;
                4'h1: data_code = `PAE_CG_D1;
                4'h2: data_code = `PAE_CG_D2;
                // (RULE12) nibbles 3 to 5
                4'h3: data_code = `PAE_CG_D3;
                4'h4: data_code = `PAE_CG_D4;
                4'h5: data_code = `PAE_CG_D5;
                4'h6: data_code = `PAE_CG_D6;
                4'h7: data_code = `PAE_CG_D7;
                4'h8: data_code = `PAE_CG_D8;
                4'h9: data_code = `PAE_CG_D9;
                4'ha: data_code = `PAE_CG_DA;
                4'hb: data_code = `PAE_CG_DB;
                4'hc: data_code = `PAE_CG_DC;
                4'hd: data_code = `PAE_CG_DD;
                4'he: data_code = `PAE_CG_DE;
                default: data_code = `PAE_CG_DF;
            endcase
        end
    endfunction

    assign in_frame = ~state[0];

    // (RULE19) one code group per clock
    always @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
            code_group <= `PAE_CG_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (tx_en) begin
                        // (RULE16) start pair replaces preamble
                        code_group <= `PAE_CG_START_J;
                        state <= ST_START_K;
                    end else begin
                        // (RULE15) idle while enable low
                        code_group <= `PAE_CG_IDLE;
                    end
                end
                ST_START_K: begin
                    code_group <= `PAE_CG_START_K;
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    if (!tx_en) begin
                        // (RULE17) end pair on enable fall
                        code_group <= `PAE_CG_END_T;
                        state <= ST_END_R;
                    end else if (tx_er) begin
                        // (RULE18) error symbol replaces data
                        code_group <= `PAE_CG_TXERR;
                    end else begin
                        // (RULE10) nibble mapped to code group
                        code_group <= data_code(txd);
                    end
                end
                ST_END_R: begin
                    code_group <= `PAE_CG_END_R;
                    state <= ST_IDLE;
                end
                default: begin
                    code_group <= `PAE_CG_IDLE;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: verif/pae_cg_tab.svh */
// data code group table for the bench side
`ifndef PAE_CG_TAB_SVH
`define PAE_CG_TAB_SVH
`define PAE_VCG '{5'h1e,5'h09,5'h14,5'h15,5'h0a,5'h0b,5'h0e,5'h0f,5'h12,5'h13,5'h16,5'h17,5'h1a,5'h1b,5'h1c,5'h1d}
`endif

/* File: verif/pae_properties.sv */
// concurrent checks on the transmit entry ports
`timescale 1ns/10ps
`include "pae_cg_tab.svh"
module pae_properties (
    // clock and reset
    input wire CLK,
    input wire RESET,
    // management
    input wire MGMT_REQ,
    input wire MGMT_WRITE,
    input wire MGMT_RVALID,
    input wire [2:0] MGMT_HIT,
    input wire [4:0] VPHY_ADDR,
    input wire [4:0] P1_ADDR,
    input wire [4:0] P2_ADDR,
    // port 1 transmit
    input wire [3:0] P1_TXD,
    input wire P1_TX_EN,
    input wire P1_TX_ER,
    input wire [4:0] P1_CODE_GROUP,
    input wire P1_IN_FRAME
);
    localparam logic [4:0] CG [16] = `PAE_VCG;
    wire idle = !P1_IN_FRAME && P1_CODE_GROUP == 5'h1f;
    wire data = P1_IN_FRAME && P1_CODE_GROUP != 5'h18 && P1_CODE_GROUP != 5'h0d;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    idle_hold_a: assert property (idle && !P1_TX_EN |=> idle)
        else $error("idle not held");
    start_pair_a: assert property (idle && P1_TX_EN |=> P1_CODE_GROUP == 5'h18 ##1 P1_CODE_GROUP == 5'h11)
        else $error("bad start pair");
    data_map_a: assert property (data && P1_TX_EN && !P1_TX_ER |=> P1_CODE_GROUP == CG[$past(P1_TXD)])
        else $error("bad data code group");
    err_symbol_a: assert property (data && P1_TX_EN && P1_TX_ER |=> P1_CODE_GROUP == 5'h04)
        else $error("no error symbol");
    end_pair_a: assert property (data && !P1_TX_EN |=> P1_CODE_GROUP == 5'h0d ##1
        (P1_CODE_GROUP == 5'h07 && !P1_IN_FRAME) ##1 P1_CODE_GROUP == 5'h1f) else $error("bad end pair");
    read_answer_a: assert property (MGMT_REQ && !MGMT_WRITE |=> MGMT_RVALID)
        else $error("read not answered");
    quiet_bus_a: assert property (!MGMT_REQ |=> !MGMT_RVALID && MGMT_HIT == 3'h0)
        else $error("answer without request");
    strap_hold_a: assert property (!$past(RESET) && !(MGMT_REQ && MGMT_WRITE)
        |=> $stable({VPHY_ADDR, P1_ADDR, P2_ADDR})) else $error("address moved");
    cover property (idle && P1_TX_EN);
    cover property (data && P1_TX_ER);
    cover property (MGMT_RVALID);
endmodule

/* File: verif/pae_mac_model.sv */
// behavioural mac side driving one mii transmit port
`timescale 1ns/10ps
module pae_mac_model #(
    parameter int SEED = 9
) (
    // clock and frame request
    input wire clk,
    input wire start,
    input wire [7:0] len,
    input wire [7:0] err_at,
    output wire busy,
    // mii transmit
    output logic [3:0] txd = 4'h0,
    output logic tx_en = 1'b0,
    output logic tx_er = 1'b0
);
    int seed = SEED;
    logic [7:0] cnt = 8'h0;
    logic [7:0] gap = 8'h0;
    assign busy = cnt != 0 || gap != 0 || tx_en;
    always @(posedge clk) begin
        txd <= 4'($random(seed));
        tx_en <= cnt != 0;
        tx_er <= cnt != 0 ? cnt == err_at : 1'($random(seed));
        if (cnt != 0)
            cnt <= cnt - 8'h1;
        else if (gap != 0)
            gap <= gap - 8'h1;
        else if (start) begin
            cnt <= len;
            gap <= 8'h2;
        end
    end
endmodule

/* File: verif/pae_phy_tx_entry_tb.sv */
// self-checking bench for the phy transmit entry
`timescale 1ns/10ps
`include "pae_cg_tab.svh"
module pae_phy_tx_entry_tb;
    logic CLK = 0, RESET = 1, ADDR_SEL_STRAP = 1, live = 0;
    logic MGMT_REQ = 0, MGMT_WRITE = 0, MGMT_DIRECT_VPHY = 0;
    logic [4:0] MGMT_PHY_ADDR = 0, MGMT_REG_ADDR = 0;
    logic [15:0] MGMT_WDATA = 0;
    logic [1:0] link = 0, start = 0;
    logic [5:0] line1 = 0, line2 = 0;
    logic [7:0] flen = 5, ferr = 0;
    wire [15:0] MGMT_RDATA;
    wire MGMT_RVALID;
    wire [2:0] MGMT_HIT;
    wire [4:0] VPHY_ADDR, P1_ADDR, P2_ADDR;
    wire [5:0] mode;
    wire [4:0] cg [2];
    wire [3:0] txd [2];
    wire [5:0] rxo [2];
    wire [1:0] ten, ter, inf, busy;
    int n_errors = 0, comparisons = 0, seed = 9;
    int st [2] = '{0, 0};
    logic [4:0] ecg [2] = '{5'h1f, 5'h1f};
    logic [5:0] erx [2] = '{6'h0, 6'h0};
    logic [4:0] tab [16] = `PAE_VCG;
    always #5 CLK = !CLK;
    pae_phy_tx_entry u_pae_phy_tx_entry (.CLK(CLK), .RESET(RESET), .ADDR_SEL_STRAP(ADDR_SEL_STRAP),
        .MGMT_REQ(MGMT_REQ), .MGMT_WRITE(MGMT_WRITE), .MGMT_DIRECT_VPHY(MGMT_DIRECT_VPHY),
        .MGMT_PHY_ADDR(MGMT_PHY_ADDR), .MGMT_REG_ADDR(MGMT_REG_ADDR), .MGMT_WDATA(MGMT_WDATA),
        .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID), .MGMT_HIT(MGMT_HIT), .VPHY_ADDR(VPHY_ADDR),
        .P1_ADDR(P1_ADDR), .P2_ADDR(P2_ADDR), .VPHY_SPEED_100(mode[5]), .VPHY_FULL_DUPLEX(mode[4]),
        .P1_SPEED_100(mode[3]), .P1_FULL_DUPLEX(mode[2]), .P2_SPEED_100(mode[1]), .P2_FULL_DUPLEX(mode[0]),
        .P1_LINK_UP(link[0]), .P2_LINK_UP(link[1]), .P1_TXD(txd[0]), .P1_TX_EN(ten[0]), .P1_TX_ER(ter[0]),
        .P1_CODE_GROUP(cg[0]), .P1_IN_FRAME(inf[0]), .P2_TXD(txd[1]), .P2_TX_EN(ten[1]), .P2_TX_ER(ter[1]),
        .P2_CODE_GROUP(cg[1]), .P2_IN_FRAME(inf[1]), .P1_LINE_RXD(line1[3:0]), .P1_LINE_RX_DV(line1[4]),
        .P1_LINE_RX_ER(line1[5]), .P1_RXD(rxo[0][3:0]), .P1_RX_DV(rxo[0][4]), .P1_RX_ER(rxo[0][5]),
        .P2_LINE_RXD(line2[3:0]), .P2_LINE_RX_DV(line2[4]), .P2_LINE_RX_ER(line2[5]), .P2_RXD(rxo[1][3:0]),
        .P2_RX_DV(rxo[1][4]), .P2_RX_ER(rxo[1][5]));
    pae_mac_model #(.SEED(9)) u_pae_mac_model_1 (.clk(CLK), .start(start[0]), .len(flen), .err_at(ferr),
        .busy(busy[0]), .txd(txd[0]), .tx_en(ten[0]), .tx_er(ter[0]));
    pae_mac_model #(.SEED(5)) u_pae_mac_model_2 (.clk(CLK), .start(start[1]), .len(flen), .err_at(ferr),
        .busy(busy[1]), .txd(txd[1]), .tx_en(ten[1]), .tx_er(ter[1]));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic mgmt(input logic wr, dir, input logic [4:0] pa, ra, input logic [15:0] wd,
                        input logic [2:0] eh, input logic [15:0] erd);
        @(posedge CLK);
        MGMT_REQ <= 1'b1;
        MGMT_WRITE <= wr;
        MGMT_DIRECT_VPHY <= dir;
        MGMT_PHY_ADDR <= pa;
        MGMT_REG_ADDR <= ra;
        MGMT_WDATA <= wd;
        @(posedge CLK);
        MGMT_REQ <= 1'b0;
        @(negedge CLK);
        check(MGMT_HIT, eh);
        check(MGMT_RVALID, !wr);
        if (!wr)
            check(MGMT_RDATA, erd);
    endtask
    task automatic do_reset(input logic s);
        @(posedge CLK);
        ADDR_SEL_STRAP <= s;
        RESET <= 1'b1;
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        repeat (2) @(posedge CLK);
        ADDR_SEL_STRAP <= !s;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
    endtask
    // reference encoder and receive copy
    always @(posedge CLK) begin
        live = 1'b1;
        for (int p = 0; p < 2; p++) begin
            erx[p] = RESET ? 6'h0 : (p == 0 ? line1 : line2);
            if (RESET) begin
                st[p] = 0;
                ecg[p] = 5'h1f;
            end else if (st[p] == 0) begin
                st[p] = ten[p];
                ecg[p] = ten[p] ? 5'h18 : 5'h1f;
            end else if (st[p] == 1) begin
                st[p] = 2;
                ecg[p] = 5'h11;
            end else if (st[p] == 2) begin
                st[p] = ten[p] ? 2 : 3;
                ecg[p] = !ten[p] ? 5'h0d : ter[p] ? 5'h04 : tab[txd[p]];
            end else begin
                ecg[p] = 5'h07;
                st[p] = 0;
            end
        end
        line1 <= 6'($random(seed));
        line2 <= 6'($random(seed));
    end
    always @(negedge CLK) begin
        for (int p = 0; p < 2 && live; p++) begin
            check(cg[p], ecg[p]);
            check(inf[p], st[p] inside {[1:3]});
            check(rxo[p], erx[p]);
        end
    end
    initial begin
        #20000;
        n_errors++;
        wrap_up;
    end
    initial begin
        link <= 2'($random(seed));
        do_reset(1'b1);
        check({VPHY_ADDR, P1_ADDR, P2_ADDR}, {5'h01, 5'h02, 5'h03});
        check(mode, 6'h3f);
        mgmt(0, 0, 5'h02, 5'h01, 0, 3'h2, {13'h0f00, link[0], 2'h0});
        mgmt(0, 1, 5'h1e, 5'h00, 0, 3'h1, 16'h3100);
        mgmt(0, 0, 5'h01, 5'h03, 0, 3'h1, 16'h0);
        mgmt(1, 0, 5'h02, 5'h12, 16'hffe5, 3'h2, 0);
        check(P1_ADDR, 5'h05);
        mgmt(1, 0, 5'h03, 5'h12, 16'h0005, 3'h4, 0);
        mgmt(0, 0, 5'h05, 5'h01, 0, 3'h6, {13'h0f00, link[0], 2'h0});
        mgmt(0, 0, 5'h05, 5'h12, 0, 3'h6, 16'h0005);
        mgmt(1, 0, 5'h05, 5'h00, 16'h0000, 3'h6, 0);
        check(mode, 6'h30);
        mgmt(1, 0, 5'h05, 5'h00, 16'h8000, 3'h6, 0);
        check(mode, 6'h3f);
        $display("management test done");
        do_reset(1'b0);
        check({VPHY_ADDR, P1_ADDR, P2_ADDR}, {5'h00, 5'h01, 5'h02});
        $display("strap test done");
        repeat (12) begin
            @(posedge CLK);
            flen <= 8'd5 + 8'($random(seed) & 15);
            ferr <= 8'($random(seed) & 3);
            start <= 2'b11;
            @(posedge CLK);
            start <= 2'b00;
            for (int i = 0; i < 200 && busy != 2'b00; i++)
                @(negedge CLK);
        end
        $display("frame test done");
        wrap_up;
    end
endmodule
bind pae_phy_tx_entry pae_properties u_pae_properties (.CLK(CLK), .RESET(RESET), .MGMT_REQ(MGMT_REQ),
    .MGMT_WRITE(MGMT_WRITE), .MGMT_RVALID(MGMT_RVALID), .MGMT_HIT(MGMT_HIT), .VPHY_ADDR(VPHY_ADDR),
    .P1_ADDR(P1_ADDR), .P2_ADDR(P2_ADDR), .P1_TXD(P1_TXD), .P1_TX_EN(P1_TX_EN), .P1_TX_ER(P1_TX_ER),
    .P1_CODE_GROUP(P1_CODE_GROUP), .P1_IN_FRAME(P1_IN_FRAME));
